/* File: bench/sys_opt_ctrl_sva.sv */
// Assertion checker for the system option register bank.
// Assumes it is bound to sys_opt_ctrl and sees only its ports.
module sys_opt_ctrl_chk
	import sys_opt_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic avs_waitrequest_out,
	input wire logic cpu_int_mask_in,
	input wire logic stop_entry_in,
	input wire logic ext_int_rise_select_out,
	input wire logic ext_int_fall_select_out,
	input wire logic ext_int_enable_out,
	input wire logic irq_low_level_out,
	input wire logic irq_falling_edge_out,
	input wire logic irq_rising_edge_out,
	input wire logic mod_a_slow_select_out,
	input wire logic mod_b_slow_select_out,
	input wire logic [PERIOD_W-1:0] pulse_length_output_a_period_out,
	input wire logic [PERIOD_W-1:0] pulse_length_output_b_period_out,
	input wire logic bus_slow_select_out,
	input wire logic watchdog_enable_bit_out,
	input wire logic watchdog_clear_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	logic hit;
	logic [2:0] g;
	assign hit = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]
		&& avs_address_in == ADDR_W'(SOC_OFFSET);
	assign g = {ext_int_rise_select_out, ext_int_fall_select_out,
		ext_int_enable_out};
	property p_decode; irq_low_level_out == (g[2:1] == 2'h0)
		&& irq_rising_edge_out == g[2] && irq_falling_edge_out == (g[2:1] != 2'h2);
	endproperty
	a_decode: assert property (p_decode) else $error("decode wrong");
	property p_per_a; pulse_length_output_a_period_out ==
		(mod_a_slow_select_out ? 13'h1000 : 13'h0100); endproperty
	a_per_a: assert property (p_per_a) else $error("period a");
	property p_per_b; pulse_length_output_b_period_out ==
		(mod_b_slow_select_out ? 13'h1000 : 13'h0100); endproperty
	a_per_b: assert property (p_per_b) else $error("period b");
	property p_mask_off; hit && !cpu_int_mask_in |=> $stable(g); endproperty
	a_mask_off: assert property (p_mask_off) else $error("masked");
	property p_mask_on; hit && cpu_int_mask_in |=>
		ext_int_enable_out == $past(avs_writedata_in[4]); endproperty
	a_mask_on: assert property (p_mask_on) else $error("enable");
	property p_wd_clr; hit && avs_writedata_in[0] |=> watchdog_clear_out
		&& watchdog_enable_bit_out; endproperty
	a_wd_clr: assert property (p_wd_clr) else $error("wd clear");
	property p_wd_keep; watchdog_enable_bit_out |=> watchdog_enable_bit_out;
	endproperty
	a_wd_keep: assert property (p_wd_keep) else $error("wd off");
	property p_stop; stop_entry_in |=> !bus_slow_select_out; endproperty
	a_stop: assert property (p_stop) else $error("slow kept");
	property p_wait; (avs_read_in || avs_write_in) && avs_waitrequest_out
		|=> !avs_waitrequest_out; endproperty
	a_wait: assert property (p_wait) else $error("wait state");
endmodule : sys_opt_ctrl_chk

bind sys_opt_ctrl sys_opt_ctrl_chk #(.ADDR_W(ADDR_W)) chk (.clk_in, .rst_n_in,
	.avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
	.avs_byteenable_in, .avs_waitrequest_out, .cpu_int_mask_in, .stop_entry_in,
	.ext_int_rise_select_out, .ext_int_fall_select_out, .ext_int_enable_out,
	.irq_low_level_out, .irq_falling_edge_out, .irq_rising_edge_out,
	.mod_a_slow_select_out, .mod_b_slow_select_out,
	.pulse_length_output_a_period_out, .pulse_length_output_b_period_out,
	.bus_slow_select_out, .watchdog_enable_bit_out, .watchdog_clear_out);

/* File: bench/tb_sys_opt_ctrl.sv */
// Self-checking bench for the system option register bank.
// Assumes the default watchdog option of zero and a 10 MHz clock.
module tb_sys_opt_ctrl
	import sys_opt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, rst_n_in = 0, avs_read_in = 0, avs_write_in = 0;
	logic power_on_in = 1, cpu_int_mask_in = 1, stop_entry_in = 0;
	logic [7:0] avs_address_in = 8'h00;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
	logic [3:0] avs_byteenable_in = 4'h1;
	logic avs_waitrequest_out, bus_enable_out, bus_slow_select_out;
	logic [PERIOD_W-1:0] pa, pb;
	logic wdc, irq_lo, irq_fe, irq_re;
	// Expected low-level, falling and rising sensitivity per select code.
	localparam logic [2:0] DEC_TBL [4] = '{3'h6, 3'h2, 3'h1, 3'h3};
	int fail_count = 0, comparisons = 0;
	always #50 clk_in = ~clk_in;
	sys_opt_ctrl uut (.clk_in, .rst_n_in, .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
		.avs_waitrequest_out, .power_on_in, .cpu_int_mask_in, .stop_entry_in,
		.ext_int_rise_select_out(), .ext_int_fall_select_out(),
		.ext_int_enable_out(), .irq_low_level_out(irq_lo),
		.irq_falling_edge_out(irq_fe),
		.irq_rising_edge_out(irq_re), .mod_a_slow_select_out(),
		.mod_b_slow_select_out(), .pulse_length_output_a_period_out(pa),
		.pulse_length_output_b_period_out(pb), .bus_slow_select_out,
		.bus_enable_out, .watchdog_enable_bit_out(),
		.watchdog_clear_out(wdc));
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Waits for the answer however long it takes; the watchdog ends a hang.
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		avs_read_in <= !wr;
		avs_write_in <= wr;
		avs_address_in <= a;
		avs_writedata_in <= {24'h0, d};
		do begin
			@(posedge clk_in);
		end while (avs_waitrequest_out !== 1'b0);
		q = avs_readdata_out;
		avs_read_in <= 1'b0;
		avs_write_in <= 1'b0;
	endtask : acc
	task automatic rd(input logic [7:0] e);
		acc(1'b0, SOC_OFFSET, 8'h00);
		chk(q, {24'h0, e});
	endtask : rd
	// The power-on level is held past release so the synchroniser sees it.
	task automatic rst(input logic po);
		rst_n_in <= 1'b0;
		power_on_in <= po;
		repeat (4) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (8) @(posedge clk_in);
		power_on_in <= 1'b0;
	endtask : rst
	task automatic count_pulses(input int exp);
		int c;
		c = 0;
		repeat (40) @(posedge clk_in);
		repeat (64) begin
			@(posedge clk_in);
			if (bus_enable_out === 1'b1) c++;
		end
		chk(c, exp);
	endtask : count_pulses
	task automatic t_reset;
		rst(1'b0);
		rd(8'h10);
		rst(1'b1);
		rd(8'h90);
	endtask : t_reset
	task automatic t_write;
		acc(1'b1, SOC_OFFSET, 8'h00);
		rd(8'h00);
		chk(pa, PERIOD_FAST);
		chk(pb, PERIOD_FAST);
		acc(1'b1, SOC_OFFSET, 8'hFF);
		// The clear pulse stands only in the cycle after the write edge.
		@(posedge clk_in);
		chk(wdc, 1'b1);
		rd(8'h7F);
		chk(pa, PERIOD_SLOW);
		chk(pb, PERIOD_SLOW);
		cpu_int_mask_in <= 1'b0;
		acc(1'b1, SOC_OFFSET, 8'h00);
		@(posedge clk_in);
		chk(wdc, 1'b0);
		rd(8'h71);
		cpu_int_mask_in <= 1'b1;
	endtask : t_write
	task automatic t_codes;
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, SOC_OFFSET, {1'b0, 2'(i), 5'h10});
			rd({1'b0, 2'(i), 5'h11});
			chk({irq_lo, irq_fe, irq_re}, DEC_TBL[i]);
		end
		acc(1'b1, 8'h0D, 8'hFF);
		chk(q, 32'h0);
		acc(1'b0, 8'h0D, 8'h00);
		chk(q, 32'h0);
		rd(8'h71);
	endtask : t_codes
	task automatic t_rate;
		count_pulses(32);
		acc(1'b1, SOC_OFFSET, 8'h02);
		count_pulses(2);
		stop_entry_in <= 1'b1;
		@(posedge clk_in);
		stop_entry_in <= 1'b0;
		rd(8'h01);
	endtask : t_rate
	initial begin
		t_reset();
		t_write();
		t_codes();
		t_rate();
		summarize();
	end
	initial begin
		repeat (3000) @(posedge clk_in);
		fail_count++;
		summarize();
	end
endmodule : tb_sys_opt_ctrl

/* File: src/bus_rate_div.sv */
// Divider that makes the bus-rate enable pulse from the oscillator clock.
// Assumes clk_in is the oscillator; slow_in comes from the same clock.
module bus_rate_div
	import sys_opt_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic slow_in,
	output logic bus_enable_out
);
	typedef struct packed {
		logic [DIV_W-1:0] count;
		logic pulse;
	} div_state_t;

	div_state_t cur_reg;
	div_state_t cur_next;

	// A change of rate takes effect at the next reload, so no short period.
	always_comb begin
		cur_next = cur_reg;
		cur_next.pulse = 1'b0;
		if (cur_reg.count == '0) begin
			cur_next.pulse = 1'b1;
			cur_next.count = slow_in ? DIV_W'(OSC_DIV_SLOW - 1)
				: DIV_W'(OSC_DIV_FAST - 1);
		end else begin
			cur_next.count = cur_reg.count - 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign bus_enable_out = cur_reg.pulse;

endmodule : bus_rate_div

/* File: src/pin_sync3.sv */
// Three-stage synchroniser for a level arriving from outside the clock.
// Assumes the level is stable for several clock cycles at a time.
module pin_sync3
	import sys_opt_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic level_in,
	output logic level_out
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic q;
	} sync_state_t;

	sync_state_t cur_reg;
	sync_state_t cur_next;

	// The output moves only when the second and third stages agree.
	always_comb begin
		cur_next = cur_reg;
		cur_next.s1 = level_in;
		cur_next.s2 = cur_reg.s1;
		cur_next.s3 = cur_reg.s2;
		if (cur_reg.s2 == cur_reg.s3) begin
			cur_next.q = cur_reg.s3;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign level_out = cur_reg.q;

endmodule : pin_sync3

/* File: src/sys_opt_ctrl.sv */
// System option register with its Avalon-MM slave and decoded controls.
// Assumes the CPU mask bit and STOP entry come from logic on clk_in and
// that the power-on level comes from an asynchronous power-on detector.
//
// Function
// - Power-on event sets the flag in bit 7
// - Writing zero clears flag, one leaves it
// - Rise/fall select bits choose the trigger
// - Sensitivity bits writable only while mask set
// - Reset clears both sensitivity bits
// - Enable bit gates interrupt, mask-gated writes
// - Reset sets the external interrupt enable
// - Modulator A bit selects 4096 or 256
// - Modulator B bit selects 4096 or 256
// - Slow bit divides bus rate by sixteen
// - Slow bit cleared by reset and STOP
// - Writing one clears and enables watchdog
// - Reset loads watchdog bit from mask option
// - Field order and reset pattern of register
//
// Decided for this implementation: the Avalon-MM interface to the registers.
module sys_opt_ctrl
	import sys_opt_pkg::*;
#(
	parameter logic WATCHDOG_OPTION = 1'b0,
	parameter int ADDR_W = 8
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic [ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic power_on_in,
	input wire logic cpu_int_mask_in,
	input wire logic stop_entry_in,
	output logic ext_int_rise_select_out,
	output logic ext_int_fall_select_out,
	output logic ext_int_enable_out,
	output logic irq_low_level_out,
	output logic irq_falling_edge_out,
	output logic irq_rising_edge_out,
	output logic mod_a_slow_select_out,
	output logic mod_b_slow_select_out,
	output logic [PERIOD_W-1:0] pulse_length_output_a_period_out,
	output logic [PERIOD_W-1:0] pulse_length_output_b_period_out,
	output logic bus_slow_select_out,
	output logic bus_enable_out,
	output logic watchdog_enable_bit_out,
	output logic watchdog_clear_out
);

	// Reset value carries the mask option in bit 0; the flag starts clear
	// and is raised by the synchronised power-on level after release.
	localparam logic [7:0] SOC_RESET =
		{SOC_RESET_BASE[7:1], WATCHDOG_OPTION};

	opt_state_t cur_reg;
	opt_state_t cur_next;
	logic power_on_sync;
	logic req;
	logic hit;

	function automatic logic [PERIOD_W-1:0] period_of(input logic slow);
		period_of = slow ? PERIOD_SLOW : PERIOD_FAST;
	endfunction : period_of

	pin_sync3 u_por_sync (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.level_in(power_on_in),
		.level_out(power_on_sync)
	);

	bus_rate_div u_bus_div (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.slow_in(cur_reg.opts[POS_BUS_SLOW]),
		.bus_enable_out(bus_enable_out)
	);

	assign req = avs_read_in | avs_write_in;
	assign hit = avs_address_in == ADDR_W'(SOC_OFFSET);

	always_comb begin
		cur_next = cur_reg;
		cur_next.wd_clear = 1'b0;
		case (cur_reg.bus)
			BUS_IDLE: begin
				if (req) begin
					cur_next.bus = BUS_ACK;
					cur_next.rdata = hit ? {24'h000000, cur_reg.opts} : READ_ZERO;
				end
			end
			BUS_ACK: begin
				cur_next.bus = BUS_IDLE;
				if (avs_write_in && hit && avs_byteenable_in[0]) begin
					// Software can only clear the power-on flag.
					if (!avs_writedata_in[POS_POWER_ON]) begin
						cur_next.opts[POS_POWER_ON] = 1'b0;
					end
					// Interrupt fields are dropped while the mask is clear.
					if (cpu_int_mask_in) begin
						cur_next.opts[POS_RISE] =
							avs_writedata_in[POS_RISE];
						cur_next.opts[POS_FALL] =
							avs_writedata_in[POS_FALL];
						cur_next.opts[POS_INT_EN] =
							avs_writedata_in[POS_INT_EN];
					end
					cur_next.opts[POS_MOD_A] = avs_writedata_in[POS_MOD_A];
					cur_next.opts[POS_MOD_B] = avs_writedata_in[POS_MOD_B];
					cur_next.opts[POS_BUS_SLOW] =
						avs_writedata_in[POS_BUS_SLOW];
					// A zero cannot switch the watchdog off.
					if (avs_writedata_in[POS_WATCHDOG]) begin
						cur_next.opts[POS_WATCHDOG] = 1'b1;
						cur_next.wd_clear = 1'b1;
					end
				end
			end
			default: begin
				cur_next.bus = BUS_IDLE;
			end
		endcase
		// Hardware set beats a software clear in the same cycle.
		if (power_on_sync) begin
			cur_next.opts[POS_POWER_ON] = 1'b1;
		end
		// STOP entry wins over a slow-mode write in the same cycle.
		if (stop_entry_in) begin
			cur_next.opts[POS_BUS_SLOW] = 1'b0;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cur_reg.bus <= BUS_IDLE;
			cur_reg.opts <= SOC_RESET;
			cur_reg.rdata <= READ_ZERO;
			cur_reg.wd_clear <= 1'b0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// One wait state: the answer stands in the cycle after the request.
	assign avs_waitrequest_out = req && (cur_reg.bus != BUS_ACK);
	assign avs_readdata_out = cur_reg.rdata;

	assign ext_int_rise_select_out = cur_reg.opts[POS_RISE];
	assign ext_int_fall_select_out = cur_reg.opts[POS_FALL];
	assign ext_int_enable_out = cur_reg.opts[POS_INT_EN];
	assign irq_low_level_out = ~cur_reg.opts[POS_RISE]
		& ~cur_reg.opts[POS_FALL];
	assign irq_falling_edge_out = ~cur_reg.opts[POS_RISE]
		| cur_reg.opts[POS_FALL];
	assign irq_rising_edge_out = cur_reg.opts[POS_RISE];
	assign mod_a_slow_select_out = cur_reg.opts[POS_MOD_A];
	assign mod_b_slow_select_out = cur_reg.opts[POS_MOD_B];
	// The speed bits are not double buffered; see the modulator users.
	assign pulse_length_output_a_period_out =
		period_of(cur_reg.opts[POS_MOD_A]);
	assign pulse_length_output_b_period_out =
		period_of(cur_reg.opts[POS_MOD_B]);
	assign bus_slow_select_out = cur_reg.opts[POS_BUS_SLOW];
	assign watchdog_enable_bit_out = cur_reg.opts[POS_WATCHDOG];
	assign watchdog_clear_out = cur_reg.wd_clear;

endmodule : sys_opt_ctrl

/* File: src/sys_opt_pkg.sv */
// Constants, field positions and types of the system option register bank.
// Assumes one 10 MHz clock and a byte-addressed Avalon-MM register bus.
package sys_opt_pkg;

	// Byte address of the option register on the register bus.
	localparam logic [7:0] SOC_OFFSET = 8'h0C;

	// Field positions inside the 8-bit option register.
	localparam int POS_POWER_ON = 7;
	localparam int POS_RISE = 6;
	localparam int POS_FALL = 5;
	localparam int POS_INT_EN = 4;
	localparam int POS_MOD_A = 3;
	localparam int POS_MOD_B = 2;
	localparam int POS_BUS_SLOW = 1;
	localparam int POS_WATCHDOG = 0;

	// Reset pattern of bits 7 to 1; bit 0 is filled in separately from the mask option.
	localparam logic [7:0] SOC_RESET_BASE = 8'h10;

	// Modulator periods in timer clock periods.
	localparam int PERIOD_W = 13;
	localparam logic [PERIOD_W-1:0] PERIOD_FAST = 13'h0100;
	localparam logic [PERIOD_W-1:0] PERIOD_SLOW = 13'h1000;

	// Bus rate: oscillator divided by two, or sixteen times slower.
	localparam int OSC_DIV_FAST = 2;
	localparam int SLOW_FACTOR = 16;
	localparam int OSC_DIV_SLOW = OSC_DIV_FAST * SLOW_FACTOR;
	localparam int DIV_W = 5;

	localparam logic [31:0] READ_ZERO = 32'h00000000;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK = 2'b01
	} bus_state_t;

	typedef struct packed {
		bus_state_t bus;
		logic [7:0] opts;
		logic [31:0] rdata;
		logic wd_clear;
	} opt_state_t;

endpackage : sys_opt_pkg
